// ### dv/pps_board.sv
`timescale 1ns/1ps
module pps_board #(
    parameter int W = 36
) (
    input wire logic ref_clk_i,
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] drv_oe_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] pin_o
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Undriven pins without pull-up wander so a missing drive is noticed
    logic [W-1:0] float_reg = '0;
    always_ff @(posedge ref_clk_i) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (drv_oe_i[i]) pin_o[i] = drv_i[i];
            else if (ext_en_i[i]) pin_o[i] = ext_val_i[i];
            else if (pullup_i[i]) pin_o[i] = 1'h1;
            else pin_o[i] = float_reg[i];
        end
    end
endmodule : pps_board

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pps_pkg::*;
    typedef struct {longint due; logic [35:0] oe, pu, pin, pmask, lvl, known;} pps_note_t;
    // ------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------
    logic ref_clk_i = 1'h0;
    logic srst_i = 1'h1;
    logic [7:0] wr_v = 8'h00;
    logic [2:0] fsel = 3'h0, ser_tx = 3'h0, ser_clk = 3'h0, ser_rx, ser_ci;
    logic [35:0] dir_v = 36'h0, plu_v = 36'h0, out_v = 36'h0, ext_en = 36'h0, ext_val = 36'h0;
    logic [35:0] pins, pin_v, oe_v, pu_v, in_v, ed = 36'h0, eplu = 36'h0, eo = 36'h0;
    logic [2:0] ef = 3'h0;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 32'h9246DB0D;
    pps_note_t q[$];
    pps_note_t nt;
    always #20 ref_clk_i = ~ref_clk_i;
    pps_board #(.W(36)) board_u (.ref_clk_i(ref_clk_i), .drv_i(pin_v), .drv_oe_i(oe_v), .pullup_i(pu_v),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pins));
    pps_top dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .port2_wr_i(wr_v[7]), .port2_direction_i(dir_v[35:30]), .port2_pullup_enable_i(plu_v[35:30]),
        .port2_out_i(out_v[35:30]), .port2_function_select_i(fsel[1:0]), .port2_pin_i(pins[35:30]),
        .port2_pin_o(pin_v[35:30]), .port2_pin_oe_o(oe_v[35:30]), .port2_pullup_o(pu_v[35:30]), .port2_in_o(in_v[35:30]),
        .port3_wr_i(wr_v[6]), .port3_direction_i(dir_v[29:26]), .port3_pullup_enable_i(plu_v[29:26]),
        .port3_out_i(out_v[29:26]), .port3_function_select_i(fsel[2:2]), .port3_pin_i(pins[29:26]),
        .port3_pin_o(pin_v[29:26]), .port3_pin_oe_o(oe_v[29:26]), .port3_pullup_o(pu_v[29:26]), .port3_in_o(in_v[29:26]),
        .port5_wr_i(wr_v[5]), .port5_direction_i(dir_v[25:24]), .port5_pullup_enable_i(plu_v[25:24]),
        .port5_out_i(out_v[25:24]), .port5_pin_i(pins[25:24]), .port5_pin_o(pin_v[25:24]),
        .port5_pin_oe_o(oe_v[25:24]), .port5_pullup_o(pu_v[25:24]), .port5_in_o(in_v[25:24]),
        .port6_wr_i(wr_v[4]), .port6_direction_i(dir_v[23:20]), .port6_pullup_enable_i(plu_v[23:20]),
        .port6_out_i(out_v[23:20]), .port6_pin_i(pins[23:20]), .port6_pin_o(pin_v[23:20]),
        .port6_pin_oe_o(oe_v[23:20]), .port6_pullup_o(pu_v[23:20]), .port6_in_o(in_v[23:20]),
        .port8_wr_i(wr_v[3]), .port8_direction_i(dir_v[19:14]), .port8_pullup_enable_i(plu_v[19:14]),
        .port8_out_i(out_v[19:14]), .port8_pin_i(pins[19:14]), .port8_pin_o(pin_v[19:14]),
        .port8_pin_oe_o(oe_v[19:14]), .port8_pullup_o(pu_v[19:14]), .port8_in_o(in_v[19:14]),
        .port9_wr_i(wr_v[2]), .port9_direction_i(dir_v[13:8]), .port9_pullup_enable_i(plu_v[13:8]),
        .port9_out_i(out_v[13:8]), .port9_pin_i(pins[13:8]), .port9_pin_o(pin_v[13:8]),
        .port9_pin_oe_o(oe_v[13:8]), .port9_pullup_o(pu_v[13:8]), .port9_in_o(in_v[13:8]),
        .portc_wr_i(wr_v[1]), .portc_direction_i(dir_v[7:2]), .portc_pullup_enable_i(plu_v[7:2]),
        .portc_out_i(out_v[7:2]), .portc_pin_i(pins[7:2]), .portc_pin_o(pin_v[7:2]),
        .portc_pin_oe_o(oe_v[7:2]), .portc_pullup_o(pu_v[7:2]), .portc_in_o(in_v[7:2]),
        .portd_wr_i(wr_v[0]), .portd_direction_i(dir_v[1:0]), .portd_pullup_enable_i(plu_v[1:0]),
        .portd_out_i(out_v[1:0]), .portd_pin_i(pins[1:0]), .portd_pin_o(pin_v[1:0]),
        .portd_pin_oe_o(oe_v[1:0]), .portd_pullup_o(pu_v[1:0]), .portd_in_o(in_v[1:0]),
        .serial0_tx_out_i(ser_tx[0]), .serial0_clock_out_i(ser_clk[0]), .serial0_rx_in_o(ser_rx[0]),
        .serial0_clock_in_o(ser_ci[0]), .serial1_tx_out_i(ser_tx[1]), .serial1_clock_out_i(ser_clk[1]),
        .serial1_rx_in_o(ser_rx[1]), .serial1_clock_in_o(ser_ci[1]), .serial2_tx_out_i(ser_tx[2]),
        .serial2_clock_out_i(ser_clk[2]), .serial2_rx_in_o(ser_rx[2]), .serial2_clock_in_o(ser_ci[2]));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [35:0] wmask(input logic [7:0] w);
        return {{6{w[7]}}, {4{w[6]}}, {2{w[5]}}, {4{w[4]}}, {6{w[3]}}, {6{w[2]}}, {6{w[1]}}, {2{w[0]}}};
    endfunction : wmask
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic do_reset(input int n);
        pps_note_t r;
        @(posedge ref_clk_i);
        srst_i <= 1'h1;
        repeat (n) @(posedge ref_clk_i);
        {ed, eplu, eo, ef} = '0;
        r = '{$time + 20, 36'h0, 36'h0, 36'h0, {36{1'h1}}, 36'h0, 36'h0};
        q.push_back(r);
        srst_i <= 1'h0;
    endtask : do_reset
    task automatic run(input int n);
        logic [35:0] d, p, o, e, v, m;
        logic [7:0] w;
        logic [2:0] f, t, c;
        pps_note_t r;
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk_i);
            {w, f, t, c} = 17'($random(seed));
            d = 36'({$random(seed), $random(seed)});
            p = 36'({$random(seed), $random(seed)});
            o = 36'({$random(seed), $random(seed)});
            e = 36'({$random(seed), $random(seed)});
            v = 36'({$random(seed), $random(seed)});
            if (f[0]) d[32:30] = {1'h0, d[31], 1'h1};
            if (f[1]) d[35:33] = {1'h0, d[34], 1'h1};
            if (f[2]) d[28:26] = {1'h0, d[27], 1'h1};
            m = wmask(w);
            ed = (ed & ~m) | (d & m);
            eplu = (eplu & ~m) | (p & m);
            eo = (eo & ~m) | (o & m);
            if (w[7]) ef[1:0] = f[1:0];
            if (w[6]) ef[2] = f[2];
            e = e & ~ed;
            r.pin = eo;
            if (ef[0]) {r.pin[31], r.pin[30]} = {c[0], t[0]};
            if (ef[1]) {r.pin[34], r.pin[33]} = {c[1], t[1]};
            if (ef[2]) {r.pin[27], r.pin[26]} = {c[2], t[2]};
            r = '{$time + 220, ed, eplu, r.pin, ed, (ed & r.pin) | (e & v) | (~ed & ~e & eplu), ed | e | eplu};
            q.push_back(r);
            wr_v <= w;
            dir_v <= d;
            plu_v <= p;
            out_v <= o;
            fsel <= f;
            ser_tx <= t;
            ser_clk <= c;
            ext_en <= e;
            ext_val <= v;
            @(posedge ref_clk_i);
            wr_v <= 8'h00;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask : run
    // ------------------------------------------------------------
    // Result watcher and main sequence
    // ------------------------------------------------------------
    always @(negedge ref_clk_i) begin
        if (q.size() > 0 && $time >= q[0].due) begin
            nt = q.pop_front();
            check(oe_v, nt.oe);
            check(pu_v, nt.pu);
            check(pin_v & nt.pmask, nt.pin & nt.pmask);
            check(in_v & nt.known, nt.lvl & nt.known);
            check(36'({ser_ci, ser_rx} & {nt.known[27], nt.known[34], nt.known[31], nt.known[28], nt.known[35],
                nt.known[32]}), 36'({nt.lvl[27], nt.lvl[34], nt.lvl[31], nt.lvl[28], nt.lvl[35], nt.lvl[32]}
                & {nt.known[27], nt.known[34], nt.known[31], nt.known[28], nt.known[35], nt.known[32]}));
        end
    end
    initial begin
        do_reset(11);
        run(60);
        do_reset(2);
        run(30);
        for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge ref_clk_i);
        if (q.size() > 0) n_fail++;
        test_done();
    end
endmodule : testbench

// ### rtl/pps_pkg.sv
package pps_pkg;
    // ------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------
    localparam int PPS_P2_W = 6;
    localparam int PPS_P3_W = 4;
    localparam int PPS_P5_W = 2;
    localparam int PPS_P6_W = 4;
    localparam int PPS_P8_W = 6;
    localparam int PPS_P9_W = 6;
    localparam int PPS_PC_W = 6;
    localparam int PPS_PD_W = 2;

    // ------------------------------------------------------------
    // Values after reset (per bit)
    // ------------------------------------------------------------
    localparam logic PPS_DIR_RST = 1'h0;
    localparam logic PPS_PLU_RST = 1'h0;
    localparam logic PPS_OUT_RST = 1'h0;
    localparam logic PPS_FSEL_RST = 1'h0;

    // ------------------------------------------------------------
    // Input synchroniser depth
    // ------------------------------------------------------------
    localparam int PPS_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Serial pin positions on port 2 and port 3
    // ------------------------------------------------------------
    localparam int PPS_P2_TX0 = 0;
    localparam int PPS_P2_CLK0 = 1;
    localparam int PPS_P2_RX0 = 2;
    localparam int PPS_P2_TX1 = 3;
    localparam int PPS_P2_CLK1 = 4;
    localparam int PPS_P2_RX1 = 5;
    localparam int PPS_P3_TX2 = 0;
    localparam int PPS_P3_CLK2 = 1;
    localparam int PPS_P3_RX2 = 2;

    // Function select fields
    localparam int PPS_FSEL2_W = 2;
    localparam int PPS_FSEL_CH0 = 0;
    localparam int PPS_FSEL_CH1 = 1;
    localparam int PPS_FSEL3_W = 1;
    localparam int PPS_FSEL_CH2 = 0;
endpackage : pps_pkg

// ### rtl/pps_port.sv
`timescale 1ns/1ps
module pps_port #(
    parameter int W = 6
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_i,
    input wire logic [W-1:0] dir_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] alt_sel_i,
    input wire logic [W-1:0] alt_out_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe_o,
    output logic [W-1:0] pullup_o,
    output logic [W-1:0] in_o
);
    import pps_pkg::*;

    // ------------------------------------------------------------
    // Configuration latches
    // ------------------------------------------------------------
    logic [W-1:0] dir_reg, dir_next;
    logic [W-1:0] plu_reg, plu_next;
    logic [W-1:0] out_reg, out_next;

    always_comb begin
        dir_next = dir_reg;
        plu_next = plu_reg;
        out_next = out_reg;
        if (wr_i) begin
            dir_next = dir_i;
            plu_next = pullup_i;
            out_next = out_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            dir_reg <= {W{PPS_DIR_RST}};
            plu_reg <= {W{PPS_PLU_RST}};
            out_reg <= {W{PPS_OUT_RST}};
        end else begin
            dir_reg <= dir_next;
            plu_reg <= plu_next;
            out_reg <= out_next;
        end
    end

    // ------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------
    logic [W-1:0] pin_reg, pin_next;
    logic [W-1:0] oe_reg, oe_next;
    logic [W-1:0] pu_reg, pu_next;

    always_comb begin
        pin_next = (alt_sel_i & alt_out_i) | (~alt_sel_i & out_reg);
        oe_next = dir_reg;
        pu_next = plu_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_reg <= {W{PPS_OUT_RST}};
            oe_reg <= {W{PPS_DIR_RST}};
            pu_reg <= {W{PPS_PLU_RST}};
        end else begin
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end

    assign pin_o = pin_reg;
    assign pin_oe_o = oe_reg;
    assign pullup_o = pu_reg;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [W-1:0] sync_reg [PPS_SYNC_STAGES];
    logic [W-1:0] sync_next [PPS_SYNC_STAGES];

    always_comb begin
        sync_next[0] = pin_i;
        for (int i = 1; i < PPS_SYNC_STAGES; i++) begin
            sync_next[i] = sync_reg[i-1];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        for (int i = 0; i < PPS_SYNC_STAGES; i++) begin
            sync_reg[i] <= sync_next[i];
        end
    end

    assign in_o = sync_reg[PPS_SYNC_STAGES-1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    dir_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        wr_i |-> ##2 pin_oe_o == $past(dir_i, 2))
        else $error("direction write not seen on output enable");
    dir_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        !wr_i |=> $stable(dir_reg))
        else $error("direction changed without a write");
    pullup_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        wr_i |-> ##2 pullup_o == $past(pullup_i, 2))
        else $error("pull-up write not seen on output");
    reset_input_a: assert property (@(posedge ref_clk_i)
        srst_i ##1 srst_i |-> pin_oe_o == '0)
        else $error("pin driven during reset");
    reset_pullup_a: assert property (@(posedge ref_clk_i)
        srst_i ##1 srst_i |-> pullup_o == '0)
        else $error("pull-up enabled during reset");
    alt_route_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (alt_sel_i != '0) |=> ((pin_o & $past(alt_sel_i)) == ($past(alt_out_i) & $past(alt_sel_i))))
        else $error("serial output not routed to pin");
    plain_port_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        (alt_sel_i == '0) |=> pin_o == $past(out_reg))
        else $error("pin does not show output latch");
    input_sync_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        1'b1 |-> ##2 in_o == $past(pin_i, 2))
        else $error("pin read not two cycles behind pin");
    cover_out_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) wr_i && dir_i != '0 ##2 pin_oe_o != '0);
    cover_alt_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) alt_sel_i != '0 ##1 pin_o != '0);
    cover_plu_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) wr_i && pullup_i != '0);
endmodule : pps_port

// ### rtl/pps_top.sv
`timescale 1ns/1ps
module pps_top (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic port2_wr_i,
    input wire logic [pps_pkg::PPS_P2_W-1:0] port2_direction_i,
    input wire logic [pps_pkg::PPS_P2_W-1:0] port2_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P2_W-1:0] port2_out_i,
    input wire logic [pps_pkg::PPS_FSEL2_W-1:0] port2_function_select_i,
    input wire logic [pps_pkg::PPS_P2_W-1:0] port2_pin_i,
    output logic [pps_pkg::PPS_P2_W-1:0] port2_pin_o,
    output logic [pps_pkg::PPS_P2_W-1:0] port2_pin_oe_o,
    output logic [pps_pkg::PPS_P2_W-1:0] port2_pullup_o,
    output logic [pps_pkg::PPS_P2_W-1:0] port2_in_o,
    input wire logic port3_wr_i,
    input wire logic [pps_pkg::PPS_P3_W-1:0] port3_direction_i,
    input wire logic [pps_pkg::PPS_P3_W-1:0] port3_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P3_W-1:0] port3_out_i,
    input wire logic [pps_pkg::PPS_FSEL3_W-1:0] port3_function_select_i,
    input wire logic [pps_pkg::PPS_P3_W-1:0] port3_pin_i,
    output logic [pps_pkg::PPS_P3_W-1:0] port3_pin_o,
    output logic [pps_pkg::PPS_P3_W-1:0] port3_pin_oe_o,
    output logic [pps_pkg::PPS_P3_W-1:0] port3_pullup_o,
    output logic [pps_pkg::PPS_P3_W-1:0] port3_in_o,
    input wire logic port5_wr_i,
    input wire logic [pps_pkg::PPS_P5_W-1:0] port5_direction_i,
    input wire logic [pps_pkg::PPS_P5_W-1:0] port5_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P5_W-1:0] port5_out_i,
    input wire logic [pps_pkg::PPS_P5_W-1:0] port5_pin_i,
    output logic [pps_pkg::PPS_P5_W-1:0] port5_pin_o,
    output logic [pps_pkg::PPS_P5_W-1:0] port5_pin_oe_o,
    output logic [pps_pkg::PPS_P5_W-1:0] port5_pullup_o,
    output logic [pps_pkg::PPS_P5_W-1:0] port5_in_o,
    input wire logic port6_wr_i,
    input wire logic [pps_pkg::PPS_P6_W-1:0] port6_direction_i,
    input wire logic [pps_pkg::PPS_P6_W-1:0] port6_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P6_W-1:0] port6_out_i,
    input wire logic [pps_pkg::PPS_P6_W-1:0] port6_pin_i,
    output logic [pps_pkg::PPS_P6_W-1:0] port6_pin_o,
    output logic [pps_pkg::PPS_P6_W-1:0] port6_pin_oe_o,
    output logic [pps_pkg::PPS_P6_W-1:0] port6_pullup_o,
    output logic [pps_pkg::PPS_P6_W-1:0] port6_in_o,
    input wire logic port8_wr_i,
    input wire logic [pps_pkg::PPS_P8_W-1:0] port8_direction_i,
    input wire logic [pps_pkg::PPS_P8_W-1:0] port8_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P8_W-1:0] port8_out_i,
    input wire logic [pps_pkg::PPS_P8_W-1:0] port8_pin_i,
    output logic [pps_pkg::PPS_P8_W-1:0] port8_pin_o,
    output logic [pps_pkg::PPS_P8_W-1:0] port8_pin_oe_o,
    output logic [pps_pkg::PPS_P8_W-1:0] port8_pullup_o,
    output logic [pps_pkg::PPS_P8_W-1:0] port8_in_o,
    input wire logic port9_wr_i,
    input wire logic [pps_pkg::PPS_P9_W-1:0] port9_direction_i,
    input wire logic [pps_pkg::PPS_P9_W-1:0] port9_pullup_enable_i,
    input wire logic [pps_pkg::PPS_P9_W-1:0] port9_out_i,
    input wire logic [pps_pkg::PPS_P9_W-1:0] port9_pin_i,
    output logic [pps_pkg::PPS_P9_W-1:0] port9_pin_o,
    output logic [pps_pkg::PPS_P9_W-1:0] port9_pin_oe_o,
    output logic [pps_pkg::PPS_P9_W-1:0] port9_pullup_o,
    output logic [pps_pkg::PPS_P9_W-1:0] port9_in_o,
    input wire logic portc_wr_i,
    input wire logic [pps_pkg::PPS_PC_W-1:0] portc_direction_i,
    input wire logic [pps_pkg::PPS_PC_W-1:0] portc_pullup_enable_i,
    input wire logic [pps_pkg::PPS_PC_W-1:0] portc_out_i,
    input wire logic [pps_pkg::PPS_PC_W-1:0] portc_pin_i,
    output logic [pps_pkg::PPS_PC_W-1:0] portc_pin_o,
    output logic [pps_pkg::PPS_PC_W-1:0] portc_pin_oe_o,
    output logic [pps_pkg::PPS_PC_W-1:0] portc_pullup_o,
    output logic [pps_pkg::PPS_PC_W-1:0] portc_in_o,
    input wire logic portd_wr_i,
    input wire logic [pps_pkg::PPS_PD_W-1:0] portd_direction_i,
    input wire logic [pps_pkg::PPS_PD_W-1:0] portd_pullup_enable_i,
    input wire logic [pps_pkg::PPS_PD_W-1:0] portd_out_i,
    input wire logic [pps_pkg::PPS_PD_W-1:0] portd_pin_i,
    output logic [pps_pkg::PPS_PD_W-1:0] portd_pin_o,
    output logic [pps_pkg::PPS_PD_W-1:0] portd_pin_oe_o,
    output logic [pps_pkg::PPS_PD_W-1:0] portd_pullup_o,
    output logic [pps_pkg::PPS_PD_W-1:0] portd_in_o,
    input wire logic serial0_tx_out_i,
    input wire logic serial0_clock_out_i,
    output logic serial0_rx_in_o,
    output logic serial0_clock_in_o,
    input wire logic serial1_tx_out_i,
    input wire logic serial1_clock_out_i,
    output logic serial1_rx_in_o,
    output logic serial1_clock_in_o,
    input wire logic serial2_tx_out_i,
    input wire logic serial2_clock_out_i,
    output logic serial2_rx_in_o,
    output logic serial2_clock_in_o
);
    import pps_pkg::*;

    // ------------------------------------------------------------
    // Function select latches
    // ------------------------------------------------------------
    logic [PPS_FSEL2_W-1:0] fsel2_reg, fsel2_next;
    logic [PPS_FSEL3_W-1:0] fsel3_reg, fsel3_next;

    always_comb begin
        fsel2_next = port2_wr_i ? port2_function_select_i : fsel2_reg;
        fsel3_next = port3_wr_i ? port3_function_select_i : fsel3_reg;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            fsel2_reg <= {PPS_FSEL2_W{PPS_FSEL_RST}};
            fsel3_reg <= {PPS_FSEL3_W{PPS_FSEL_RST}};
        end else begin
            fsel2_reg <= fsel2_next;
            fsel3_reg <= fsel3_next;
        end
    end

    // ------------------------------------------------------------
    // Serial pin sharing
    // ------------------------------------------------------------
    logic [PPS_P2_W-1:0] p2_alt_sel, p2_alt_out;
    logic [PPS_P3_W-1:0] p3_alt_sel, p3_alt_out;

    always_comb begin
        p2_alt_sel = '0;
        p2_alt_out = '0;
        p3_alt_sel = '0;
        p3_alt_out = '0;
        p2_alt_sel[PPS_P2_TX0] = fsel2_reg[PPS_FSEL_CH0];
        p2_alt_sel[PPS_P2_CLK0] = fsel2_reg[PPS_FSEL_CH0];
        p2_alt_sel[PPS_P2_TX1] = fsel2_reg[PPS_FSEL_CH1];
        p2_alt_sel[PPS_P2_CLK1] = fsel2_reg[PPS_FSEL_CH1];
        p3_alt_sel[PPS_P3_TX2] = fsel3_reg[PPS_FSEL_CH2];
        p3_alt_sel[PPS_P3_CLK2] = fsel3_reg[PPS_FSEL_CH2];
        p2_alt_out[PPS_P2_TX0] = serial0_tx_out_i;
        p2_alt_out[PPS_P2_CLK0] = serial0_clock_out_i;
        p2_alt_out[PPS_P2_TX1] = serial1_tx_out_i;
        p2_alt_out[PPS_P2_CLK1] = serial1_clock_out_i;
        p3_alt_out[PPS_P3_TX2] = serial2_tx_out_i;
        p3_alt_out[PPS_P3_CLK2] = serial2_clock_out_i;
    end

    // Receive and clock inputs come from the synchronised pin reads
    assign serial0_rx_in_o = port2_in_o[PPS_P2_RX0];
    assign serial0_clock_in_o = port2_in_o[PPS_P2_CLK0];
    assign serial1_rx_in_o = port2_in_o[PPS_P2_RX1];
    assign serial1_clock_in_o = port2_in_o[PPS_P2_CLK1];
    assign serial2_rx_in_o = port3_in_o[PPS_P3_RX2];
    assign serial2_clock_in_o = port3_in_o[PPS_P3_CLK2];

    // ------------------------------------------------------------
    // Port instances
    // ------------------------------------------------------------
    pps_port #(.W(PPS_P2_W)) u_port2 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port2_wr_i),
        .dir_i(port2_direction_i), .pullup_i(port2_pullup_enable_i), .out_i(port2_out_i),
        .alt_sel_i(p2_alt_sel), .alt_out_i(p2_alt_out), .pin_i(port2_pin_i),
        .pin_o(port2_pin_o), .pin_oe_o(port2_pin_oe_o), .pullup_o(port2_pullup_o), .in_o(port2_in_o)
    );
    pps_port #(.W(PPS_P3_W)) u_port3 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port3_wr_i),
        .dir_i(port3_direction_i), .pullup_i(port3_pullup_enable_i), .out_i(port3_out_i),
        .alt_sel_i(p3_alt_sel), .alt_out_i(p3_alt_out), .pin_i(port3_pin_i),
        .pin_o(port3_pin_o), .pin_oe_o(port3_pin_oe_o), .pullup_o(port3_pullup_o), .in_o(port3_in_o)
    );
    // Plain ports carry no serial function
    pps_port #(.W(PPS_P5_W)) u_port5 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port5_wr_i),
        .dir_i(port5_direction_i), .pullup_i(port5_pullup_enable_i), .out_i(port5_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(port5_pin_i),
        .pin_o(port5_pin_o), .pin_oe_o(port5_pin_oe_o), .pullup_o(port5_pullup_o), .in_o(port5_in_o)
    );
    pps_port #(.W(PPS_P6_W)) u_port6 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port6_wr_i),
        .dir_i(port6_direction_i), .pullup_i(port6_pullup_enable_i), .out_i(port6_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(port6_pin_i),
        .pin_o(port6_pin_o), .pin_oe_o(port6_pin_oe_o), .pullup_o(port6_pullup_o), .in_o(port6_in_o)
    );
    pps_port #(.W(PPS_P8_W)) u_port8 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port8_wr_i),
        .dir_i(port8_direction_i), .pullup_i(port8_pullup_enable_i), .out_i(port8_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(port8_pin_i),
        .pin_o(port8_pin_o), .pin_oe_o(port8_pin_oe_o), .pullup_o(port8_pullup_o), .in_o(port8_in_o)
    );
    pps_port #(.W(PPS_P9_W)) u_port9 (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(port9_wr_i),
        .dir_i(port9_direction_i), .pullup_i(port9_pullup_enable_i), .out_i(port9_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(port9_pin_i),
        .pin_o(port9_pin_o), .pin_oe_o(port9_pin_oe_o), .pullup_o(port9_pullup_o), .in_o(port9_in_o)
    );
    pps_port #(.W(PPS_PC_W)) u_portc (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(portc_wr_i),
        .dir_i(portc_direction_i), .pullup_i(portc_pullup_enable_i), .out_i(portc_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(portc_pin_i),
        .pin_o(portc_pin_o), .pin_oe_o(portc_pin_oe_o), .pullup_o(portc_pullup_o), .in_o(portc_in_o)
    );
    pps_port #(.W(PPS_PD_W)) u_portd (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_i(portd_wr_i),
        .dir_i(portd_direction_i), .pullup_i(portd_pullup_enable_i), .out_i(portd_out_i),
        .alt_sel_i('0), .alt_out_i('0), .pin_i(portd_pin_i),
        .pin_o(portd_pin_o), .pin_oe_o(portd_pin_oe_o), .pullup_o(portd_pullup_o), .in_o(portd_in_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    fsel_tx0_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        port2_wr_i && !port2_function_select_i[PPS_FSEL_CH0]
        |-> ##2 port2_pin_o[PPS_P2_TX0] == $past(port2_out_i[PPS_P2_TX0], 2))
        else $error("transmit pin taken without function select");
    rx_route_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        1'b1 |-> ##2 serial2_rx_in_o == $past(port3_pin_i[PPS_P3_RX2], 2))
        else $error("receive pin not routed to serial input");
    cover_ser_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) fsel2_reg == 2'h3 && port2_pin_oe_o != '0);
endmodule : pps_top
